// File: core/init2_seq_pkg.sv
// Constants for the phase-2 initialization nibble sequencer.
// Assumes a 25 MHz system clock and a classic Wishbone register bus.
`default_nettype none
package init2_seq_pkg;
    // Register byte addresses
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] IDENT_ADDR = 8'h04;
    localparam logic [7:0] DATE_ADDR = 8'h08;
    localparam logic [7:0] SERIAL_ADDR = 8'h0c;
    localparam logic [7:0] STATUS_ADDR = 8'h10;
    // Control fields
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_SYNC_BIT = 1;
    localparam int CTRL_EXT_BIT = 2;
    localparam int CTRL_AXIS_LSB = 4;
    localparam int CTRL_RANGE_LSB = 8;
    localparam logic [9:0] CTRL_MASK = 10'h336;
    localparam logic [9:0] CTRL_RESET = 10'h000;
    // Ident fields: maker code, config one, config two, config six
    localparam int MAKER_LSB = 0;
    localparam int CFG1_LSB = 8;
    localparam int CFG2_LSB = 16;
    localparam int CFG6_LSB = 24;
    localparam logic [31:0] IDENT_RESET = 32'h0000_0000;
    // Date fields: year 7 bits, month 4 bits, day 5 bits
    localparam int YEAR_LSB = 0;
    localparam int MONTH_LSB = 8;
    localparam int DAY_LSB = 16;
    localparam logic [31:0] DATE_RESET = 32'h0000_0000;
    localparam logic [31:0] SERIAL_RESET = 32'h0000_0000;
    // Status fields
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int STAT_PAGE_BIT = 2;
    localparam int STAT_SLOT_LSB = 8;
    localparam int STAT_REP_LSB = 16;
    localparam int STAT_CNT_LSB = 20;
    // Link codes
    localparam logic [9:0] ID_BASE = 10'h200;
    localparam logic [9:0] DATA_BASE = 10'h210;
    localparam logic [3:0] PROTO_REV = 4'h4;
    localparam logic [7:0] BLOCK_COUNT = 8'h20;
    localparam logic [7:0] SENSOR_TYPE = 8'h01;
    localparam logic [3:0] RANGE_BASE = 4'h7;
    localparam int NUM_FIELDS = 32;
    localparam int K_ASYNC = 8;
    localparam int K_SYNC = 4;
    localparam int TOTAL_ASYNC = 512;
    localparam int TOTAL_SYNC = 256;
    // Timing
    localparam int CLK_MHZ = 25;
    localparam int ASYNC_PERIOD_US = 228;
    localparam int ASYNC_CYCLES = ASYNC_PERIOD_US * CLK_MHZ;
    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN = 3'b010,
        ST_DONE = 3'b100
    } seq_state_t;
endpackage
`default_nettype wire

// File: core/init2_seq.sv
// Phase-2 initialization sequencer: sends 32 ID/data nibble pairs in 10-bit mode.
// Assumes one 25 MHz clock, a Wishbone master, and an async sync-pulse pin.
//
// The register addresses and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// (RL1) Sends identity, config and serial nibbles; serial byte zero first, high nibble of each byte first, slots 19-26.
// (RL2) Asynchronous: 228 us period, each pair eight times, 512 transmissions.
// (RL3) Synchronous: on sync pulses, each pair four times, 256 transmissions.
// (RL4) Slot one at address 0000 carries protocol revision 0100.
// (RL5) Slots two and three carry block count 32 as 0010 then 0000.
// (RL6) Slots six and seven carry sensor type 0000 then 0001.
// (RL7) Slot eight encodes axis setting as setting shifted up two bits.
// (RL8) Slot nine encodes range: 0111, 1000, 1001, 1010.
// (RL9) Slots 15-18 carry the Julian date, year first.
// (RL10) Slots 27-31 pack raw offset and averaged self-test value.
// (RL11) With extended data off, offset and self-test slots send 0000.
// (RL12) Slot 32 sends config one upper nibble if extended, else 0000.
// (RL13) Results not yet ready when their slot comes send zeros.
// (RL14) Maker code, config two, product revision and config six fill slots 4-5, 10-14.
// (RL15) Nibble address counts 0-15 twice; page is 0 then 1.
// (RL16) Each data nibble pairs with block ID 1-16 in reserved negative codes.
// (RL17) One ID then one data word, pair repeated k times per field.
// (RL18) After all transmissions the device moves on to phase 3.
module init2_seq #(
    parameter int ASYNC_PERIOD_CYCLES = init2_seq_pkg::ASYNC_CYCLES,
    parameter logic [7:0] PRODUCT_REV = 8'h11 // Arbitrary value
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic sync_pulse_i,
    input wire logic [9:0] raw_offset_i,
    input wire logic raw_offset_ready_i,
    input wire logic [9:0] averaged_selftest_result_i,
    input wire logic selftest_ready_i,
    output logic tx_valid_o,
    output logic [9:0] tx_word_o,
    output logic phase3_o
);
    init2_seq_pkg::seq_state_t state_q;
    logic [9:0] ctrl_q;
    logic [31:0] ident_q, date_q, serial_q;
    logic start_q, mode_sync_q;
    logic sync_meta_q, sync_q, sync_prev_q;
    logic [12:0] base_cnt_q;
    logic [4:0] slot_q;
    logic [2:0] rep_q;
    logic half_q;
    logic [9:0] tx_cnt_q;
    logic tick, last_rep, bus_req;
    logic [3:0] nibble;
    logic [9:0] off_eff, st_eff;
    logic [31:0] rd_data;
    logic [31:0] ctrl_merged;
    logic [7:0] maker_code, device_config_one, device_config_two, device_config_six;
    logic [7:0] serial_byte_zero, serial_byte_one, serial_byte_two, serial_byte_three;
    logic [6:0] julian_year;
    logic [3:0] julian_month;
    logic [4:0] julian_day;
    logic extended_init_data_enable;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign ctrl_merged = merge({22'h0, ctrl_q}, wb_dat_i, wb_sel_i);
    assign maker_code = ident_q[init2_seq_pkg::MAKER_LSB +: 8];
    assign device_config_one = ident_q[init2_seq_pkg::CFG1_LSB +: 8];
    assign device_config_two = ident_q[init2_seq_pkg::CFG2_LSB +: 8];
    assign device_config_six = ident_q[init2_seq_pkg::CFG6_LSB +: 8];
    assign julian_year = date_q[init2_seq_pkg::YEAR_LSB +: 7];
    assign julian_month = date_q[init2_seq_pkg::MONTH_LSB +: 4];
    assign julian_day = date_q[init2_seq_pkg::DAY_LSB +: 5];
    assign serial_byte_zero = serial_q[7:0];
    assign serial_byte_one = serial_q[15:8];
    assign serial_byte_two = serial_q[23:16];
    assign serial_byte_three = serial_q[31:24];
    assign extended_init_data_enable = ctrl_q[init2_seq_pkg::CTRL_EXT_BIT];

    // Wishbone slave: ack one cycle after the strobe, unmapped reads give zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= init2_seq_pkg::CTRL_RESET;
            ident_q <= init2_seq_pkg::IDENT_RESET;
            date_q <= init2_seq_pkg::DATE_RESET;
            serial_q <= init2_seq_pkg::SERIAL_RESET;
            start_q <= 1'b0;
        end else begin
            start_q <= 1'b0;
            if (bus_req && wb_we_i) begin
                unique case (wb_adr_i)
                    init2_seq_pkg::CTRL_ADDR: begin
                        ctrl_q <= ctrl_merged[9:0]
                                  & init2_seq_pkg::CTRL_MASK;
                        start_q <= wb_sel_i[0] && wb_dat_i[init2_seq_pkg::CTRL_START_BIT];
                    end
                    init2_seq_pkg::IDENT_ADDR: ident_q <= merge(ident_q, wb_dat_i, wb_sel_i);
                    init2_seq_pkg::DATE_ADDR: date_q <= merge(date_q, wb_dat_i, wb_sel_i);
                    init2_seq_pkg::SERIAL_ADDR: serial_q <= merge(serial_q, wb_dat_i, wb_sel_i);
                    default: ;
                endcase
            end
        end
    end

    always_comb begin
        rd_data = 32'h0000_0000;
        unique case (wb_adr_i)
            init2_seq_pkg::CTRL_ADDR: rd_data = {22'h0, ctrl_q};
            init2_seq_pkg::IDENT_ADDR: rd_data = ident_q;
            init2_seq_pkg::DATE_ADDR: rd_data = date_q;
            init2_seq_pkg::SERIAL_ADDR: rd_data = serial_q;
            init2_seq_pkg::STATUS_ADDR: begin
                rd_data[init2_seq_pkg::STAT_BUSY_BIT] = (state_q == init2_seq_pkg::ST_RUN);
                rd_data[init2_seq_pkg::STAT_DONE_BIT] = (state_q == init2_seq_pkg::ST_DONE);
                rd_data[init2_seq_pkg::STAT_PAGE_BIT] = slot_q[4];
                rd_data[init2_seq_pkg::STAT_SLOT_LSB +: 5] = slot_q;
                rd_data[init2_seq_pkg::STAT_REP_LSB +: 3] = rep_q;
                rd_data[init2_seq_pkg::STAT_CNT_LSB +: 10] = tx_cnt_q;
            end
            default: ;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (bus_req) begin
            wb_dat_o <= rd_data;
        end
    end

    // Sync pulse pin crosses in through two flops before the edge detector
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_meta_q <= 1'b0;
            sync_q <= 1'b0;
            sync_prev_q <= 1'b0;
        end else begin
            sync_meta_q <= sync_pulse_i;
            sync_q <= sync_meta_q;
            sync_prev_q <= sync_q;
        end
    end

    // Free timebase restarts with each sequence so the first word lands one period in
    always_ff @(posedge clk_i) begin
        if (rst_i || start_q || base_cnt_q == 13'(ASYNC_PERIOD_CYCLES - 1)) begin
            base_cnt_q <= 13'h0000;
        end else begin
            base_cnt_q <= base_cnt_q + 13'h0001;
        end
    end

    assign tick = (state_q == init2_seq_pkg::ST_RUN) && (mode_sync_q ? // RL3
                  (sync_q && !sync_prev_q) :
                  (base_cnt_q == 13'(ASYNC_PERIOD_CYCLES - 1))); // RL2
    assign last_rep = mode_sync_q ? (rep_q == 3'(init2_seq_pkg::K_SYNC - 1)) : // RL3
                      (rep_q == 3'(init2_seq_pkg::K_ASYNC - 1)); // RL2

    // Results not finished by their slot go out as zeros
    assign off_eff = (extended_init_data_enable && raw_offset_ready_i) ? // RL11 RL13
                     raw_offset_i : 10'h000;
    assign st_eff = (extended_init_data_enable && selftest_ready_i) ? // RL11 RL13
                    averaged_selftest_result_i : 10'h000;

    always_comb begin
        nibble = 4'h0;
        unique case (slot_q)
            5'd0: nibble = init2_seq_pkg::PROTO_REV; // RL4
            5'd1: nibble = init2_seq_pkg::BLOCK_COUNT[7:4]; // RL5
            5'd2: nibble = init2_seq_pkg::BLOCK_COUNT[3:0]; // RL5
            5'd3: nibble = maker_code[7:4]; // RL14
            5'd4: nibble = maker_code[3:0]; // RL14
            5'd5: nibble = init2_seq_pkg::SENSOR_TYPE[7:4]; // RL6
            5'd6: nibble = init2_seq_pkg::SENSOR_TYPE[3:0]; // RL6
            5'd7: nibble = {ctrl_q[init2_seq_pkg::CTRL_AXIS_LSB +: 2], 2'b00}; // RL7
            5'd8: nibble = init2_seq_pkg::RANGE_BASE // RL8
                           + {2'b00, ctrl_q[init2_seq_pkg::CTRL_RANGE_LSB +: 2]};
            5'd9: nibble = device_config_two[7:4]; // RL14
            5'd10: nibble = device_config_two[3:0]; // RL14
            5'd11: nibble = PRODUCT_REV[7:4]; // RL14
            5'd12: nibble = PRODUCT_REV[3:0]; // RL14
            5'd13: nibble = device_config_six[3:0]; // RL14
            5'd14: nibble = julian_year[6:3]; // RL9
            5'd15: nibble = {julian_year[2:0], julian_month[3]}; // RL9
            5'd16: nibble = {julian_month[2:0], julian_day[4]}; // RL9
            5'd17: nibble = julian_day[3:0]; // RL9
            5'd18: nibble = serial_byte_zero[7:4]; // RL1
            5'd19: nibble = serial_byte_zero[3:0]; // RL1
            5'd20: nibble = serial_byte_one[7:4]; // RL1
            5'd21: nibble = serial_byte_one[3:0]; // RL1
            5'd22: nibble = serial_byte_two[7:4]; // RL1
            5'd23: nibble = serial_byte_two[3:0]; // RL1
            5'd24: nibble = serial_byte_three[7:4]; // RL1
            5'd25: nibble = serial_byte_three[3:0]; // RL1
            5'd26: nibble = off_eff[3:0]; // RL10
            5'd27: nibble = off_eff[7:4]; // RL10
            5'd28: nibble = {st_eff[1:0], off_eff[9:8]}; // RL10
            5'd29: nibble = st_eff[5:2]; // RL10
            5'd30: nibble = st_eff[9:6]; // RL10
            5'd31: nibble = extended_init_data_enable ? device_config_one[7:4] : 4'h0; // RL12
            default: nibble = 4'h0;
        endcase
    end

    // Sequencer: slot, repetition and ID/data half counters
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= init2_seq_pkg::ST_IDLE;
            mode_sync_q <= 1'b0;
            slot_q <= 5'h00;
            rep_q <= 3'h0;
            half_q <= 1'b0;
        end else if (start_q && state_q != init2_seq_pkg::ST_RUN) begin
            // A start while running only restarts the timebase; a finished sequence may be rerun
            state_q <= init2_seq_pkg::ST_RUN;
            mode_sync_q <= ctrl_q[init2_seq_pkg::CTRL_SYNC_BIT];
            slot_q <= 5'h00;
            rep_q <= 3'h0;
            half_q <= 1'b0;
        end else if (tick) begin
            half_q <= !half_q; // RL17
            if (half_q) begin
                rep_q <= last_rep ? 3'h0 : rep_q + 3'h1; // RL17
                if (last_rep) begin
                    slot_q <= slot_q + 5'h01; // RL15
                    if (slot_q == 5'(init2_seq_pkg::NUM_FIELDS - 1)) begin
                        state_q <= init2_seq_pkg::ST_DONE; // RL18
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_valid_o <= 1'b0;
            tx_word_o <= 10'h000;
            tx_cnt_q <= 10'h000;
            phase3_o <= 1'b0;
        end else begin
            tx_valid_o <= tick;
            phase3_o <= (state_q == init2_seq_pkg::ST_DONE); // RL18
            if (start_q && state_q != init2_seq_pkg::ST_RUN) begin
                tx_cnt_q <= 10'h000;
            end else if (tick) begin
                tx_cnt_q <= tx_cnt_q + 10'h001;
                // Address wraps after 15, so the ID alone does not tell the page
                tx_word_o <= half_q ? init2_seq_pkg::DATA_BASE + {6'h00, nibble} : // RL16
                             init2_seq_pkg::ID_BASE + {6'h00, slot_q[3:0]}; // RL15 RL16
            end
        end
    end

    sequence id_sent_s;
        tx_valid_o && tx_word_o[9:4] == init2_seq_pkg::ID_BASE[9:4];
    endsequence
    sequence data_sent_s;
        tx_valid_o && tx_word_o[9:4] == init2_seq_pkg::DATA_BASE[9:4];
    endsequence

    total_async_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL2
        $rose(state_q == init2_seq_pkg::ST_DONE) && !mode_sync_q
        |-> tx_cnt_q == 10'(init2_seq_pkg::TOTAL_ASYNC)) else $error("async total wrong");
    total_sync_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL3
        $rose(state_q == init2_seq_pkg::ST_DONE) && mode_sync_q
        |-> tx_cnt_q == 10'(init2_seq_pkg::TOTAL_SYNC)) else $error("sync total wrong");
    proto_rev_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL4
        tick && half_q && slot_q == 5'd0 ##1 1'b1
        |-> tx_word_o == init2_seq_pkg::DATA_BASE + 10'h004) else $error("bad revision");
    block_count_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL5
        tick && half_q && slot_q == 5'd1 |=> tx_word_o == init2_seq_pkg::DATA_BASE + 10'h002)
        else $error("bad block count");
    final_slot_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL12
        tick && half_q && slot_q == 5'd31 && !extended_init_data_enable
        |=> tx_word_o == init2_seq_pkg::DATA_BASE) else $error("slot 32 not zero");
    ext_zero_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL11
        tick && half_q && slot_q >= 5'd26 && !extended_init_data_enable
        |=> tx_word_o == init2_seq_pkg::DATA_BASE) else $error("result not zeroed");
    id_then_data_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL17
        data_sent_s |-> $past(tx_word_o[3:0]) == slot_q[3:0] || slot_q != $past(slot_q))
        else $error("data word not paired");
    id_address_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL15
        tick && !half_q |=> id_sent_s ##0 tx_word_o[3:0] == $past(slot_q[3:0]))
        else $error("ID address wrong");
    phase3_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL18
        state_q == init2_seq_pkg::ST_DONE |=> phase3_o && !tx_valid_o)
        else $error("phase 3 not signalled");
    async_pace_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL2
        tx_valid_o && !mode_sync_q |=> !tx_valid_o [*2]) else $error("async pace too fast");
endmodule // init2_seq

`default_nettype wire

// File: tb/sync_pulse_source.sv
// Far-side model: sync pulse source of the receiving control unit.
// Assumes the bench raises en_i only for a synchronous run; the line idles low otherwise.
`timescale 1ns/1ps
`default_nettype none
module sync_pulse_source #(
    parameter int PERIOD = 12
) (
    input wire logic clk_i,
    input wire logic en_i,
    output logic sync_o
);
    int cnt = 0;
    always @(posedge clk_i) begin
        cnt <= (!en_i || cnt == PERIOD - 1) ? 0 : cnt + 1;
    end
    // Three cycles high so the two-flop synchroniser cannot miss a pulse
    assign sync_o = en_i && (cnt < 3);
endmodule // sync_pulse_source
`default_nettype wire

// File: tb/init_phase2_nibble_sequencer_tb_top.sv
// Bench for the phase-2 nibble sequencer: Wishbone tasks, word and read scoreboards.
// Assumes the sync pulse source model drives sync_pulse_i.
`timescale 1ns/1ps
`default_nettype none
module init_phase2_nibble_sequencer_tb_top;
    localparam logic [7:0] PREV = 8'h5a; // Arbitrary value
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, sync_en = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0, dat_o, ident, date, ser;
    logic ack, sync, tx_valid, phase3, off_rdy = 1'b0, st_rdy = 1'b0;
    logic [9:0] off = 10'h000, st = 10'h000, tx_word;
    logic [9:0] tx_q[$];
    logic [31:0] rd_q[$];
    int mismatches = 0, checks_done = 0, words = 0;
    always #20 clk_i = ~clk_i;
    init2_seq #(.ASYNC_PERIOD_CYCLES(8), .PRODUCT_REV(PREV)) uut (.clk_i(clk_i),
        .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .sync_pulse_i(sync), .raw_offset_i(off), .raw_offset_ready_i(off_rdy),
        .averaged_selftest_result_i(st), .selftest_ready_i(st_rdy),
        .tx_valid_o(tx_valid), .tx_word_o(tx_word), .phase3_o(phase3));
    sync_pulse_source #(.PERIOD(12)) far (.clk_i(clk_i), .en_i(sync_en), .sync_o(sync));
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic bad(input string m);
        mismatches++;
        $display("BAD %0t %s", $time, m);
    endtask
    task automatic cmp10(input logic [9:0] g, input logic [9:0] e);
        checks_done++;
        if (g !== e) bad($sformatf("word %h expected %h", g, e));
    endtask
    task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) bad($sformatf("value %h expected %h", g, e));
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        dat <= d;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_i);
            if (ack === 1'b1) break;
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n == 20) begin
            bad("no bus answer");
            end_sim();
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        wb(1'b0, a, 4'hf, 32'h0);
    endtask
    function automatic logic [3:0] nib(int s, logic ext, logic [9:0] ctl, logic rdy);
        logic [7:0] b;
        logic [3:0] r;
        case (s)
            0: r = init2_seq_pkg::PROTO_REV;
            1: r = init2_seq_pkg::BLOCK_COUNT[7:4];
            2: r = init2_seq_pkg::BLOCK_COUNT[3:0];
            3: r = ident[7:4];
            4: r = ident[3:0];
            5: r = init2_seq_pkg::SENSOR_TYPE[7:4];
            6: r = init2_seq_pkg::SENSOR_TYPE[3:0];
            7: r = {ctl[5:4], 2'b00};
            8: r = init2_seq_pkg::RANGE_BASE + {2'b00, ctl[9:8]};
            9: r = ident[23:20];
            10: r = ident[19:16];
            11: r = PREV[7:4];
            12: r = PREV[3:0];
            13: r = ident[27:24];
            14: r = date[6:3];
            15: r = {date[2:0], date[11]};
            16: r = {date[10:8], date[20]};
            17: r = date[19:16];
            26: r = off[3:0];
            27: r = off[7:4];
            28: r = {st[1:0], off[9:8]};
            29: r = st[5:2];
            30: r = st[9:6];
            31: r = ident[15:12];
            default: begin
                b = 8'(ser >> (8 * ((s - 18) / 2)));
                r = s[0] ? b[3:0] : b[7:4];
            end
        endcase
        // Offset and self-test slots fall to zero unless enabled and ready, the trailing slot 31 unless enabled
        if (s >= 26 && !(ext && (rdy || s == 31))) r = 4'h0;
        return r;
    endfunction
    always @(posedge clk_i) begin
        if (tx_valid === 1'b1) begin
            words++;
            if (tx_q.size() == 0) bad("unexpected word");
            else cmp10(tx_word, tx_q.pop_front());
        end
        if (ack === 1'b1 && we === 1'b0) begin
            if (rd_q.size() == 0) bad("unexpected read");
            else cmp32(dat_o, rd_q.pop_front());
        end
    end
    task automatic run(input logic sm, input logic ext, input logic rdy);
        logic [9:0] ctl;
        int k, s, j, n, tot;
        ctl = {2'($urandom), 2'b00, 2'($urandom), 1'b0, ext, sm, 1'b1};
        ident = $urandom;
        date = $urandom & 32'h001f_0f7f;
        ser = $urandom;
        off <= 10'($urandom);
        st <= 10'($urandom);
        off_rdy <= rdy;
        st_rdy <= rdy;
        wb(1'b1, init2_seq_pkg::IDENT_ADDR, 4'hf, ident);
        wb(1'b1, init2_seq_pkg::DATE_ADDR, 4'hf, date);
        wb(1'b1, init2_seq_pkg::SERIAL_ADDR, 4'hf, ser);
        k = sm ? init2_seq_pkg::K_SYNC : init2_seq_pkg::K_ASYNC;
        for (s = 0; s < init2_seq_pkg::NUM_FIELDS; s++) begin
            for (j = 0; j < k; j++) begin
                tx_q.push_back(init2_seq_pkg::ID_BASE + 10'(s % 16));
                tx_q.push_back(init2_seq_pkg::DATA_BASE + {6'h00, nib(s, ext, ctl, rdy)});
            end
        end
        words = 0;
        wb(1'b1, init2_seq_pkg::CTRL_ADDR, 4'hf, {22'h0, ctl});
        sync_en <= sm;
        repeat (4) @(posedge clk_i);
        for (n = 0; n < 10000 && phase3 !== 1'b1; n++) @(posedge clk_i);
        sync_en <= 1'b0;
        if (n == 10000) begin
            bad("phase 2 never ended");
            end_sim();
        end
        repeat (4) @(posedge clk_i);
        tot = sm ? init2_seq_pkg::TOTAL_SYNC : init2_seq_pkg::TOTAL_ASYNC;
        cmp32(words, tot);
        cmp32({31'h0, phase3}, 32'h1);
        rd(init2_seq_pkg::CTRL_ADDR, {22'h0, ctl & init2_seq_pkg::CTRL_MASK});
        // Done, idle, slot wrapped to zero and the word count kept for software
        rd(init2_seq_pkg::STATUS_ADDR, (32'(tot) << init2_seq_pkg::STAT_CNT_LSB)
           | (32'h0000_0001 << init2_seq_pkg::STAT_DONE_BIT));
    endtask
    initial begin
        void'($urandom(23630));
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(init2_seq_pkg::CTRL_ADDR, {22'h0, init2_seq_pkg::CTRL_RESET});
        rd(init2_seq_pkg::IDENT_ADDR, init2_seq_pkg::IDENT_RESET);
        rd(init2_seq_pkg::DATE_ADDR, init2_seq_pkg::DATE_RESET);
        rd(init2_seq_pkg::SERIAL_ADDR, init2_seq_pkg::SERIAL_RESET);
        rd(8'h20, 32'h0);
        wb(1'b1, init2_seq_pkg::IDENT_ADDR, 4'hf, 32'h1122_3344);
        wb(1'b1, init2_seq_pkg::IDENT_ADDR, 4'h2, 32'haabb_ccdd);
        rd(init2_seq_pkg::IDENT_ADDR, 32'h1122_cc44);
        run(1'b0, 1'b1, 1'b1);
        run(1'b1, 1'b1, 1'b0);
        run(1'b0, 1'b0, 1'b1);
        end_sim();
    end
endmodule // init_phase2_nibble_sequencer_tb_top
`default_nettype wire
